// >>> verilog/dsa_regs.svh
// Constants for the decrement and subtract datapath
`ifndef DSA_REGS_SVH
`define DSA_REGS_SVH

// ============================================================
// Widths and sizes
`define DSA_DATA_W 8
`define DSA_ADDR_W 4
`define DSA_DEPTH 16

// ============================================================
// Arithmetic constants and reset values
`define DSA_ONE 8'h01
`define DSA_ZERO_BYTE 8'h00
`define DSA_ACC_RESET 8'h00
`define DSA_FLAG_RESET 1'b0
`define DSA_DC_BIT 4
`define DSA_C_BIT 8

`endif

// >>> verilog/dsa_pkg.sv
// Types shared by the decrement and subtract datapath
`include "dsa_regs.svh"

package dsa_pkg;

    // ============================================================
    // Instruction codes
    typedef enum logic [2:0] {
        op_nop = 3'b000,
        op_decrement_to_register = 3'b001,
        op_subtract_to_accumulator = 3'b010,
        op_subtract_to_register = 3'b011,
        op_subtract_borrow_to_accumulator = 3'b100,
        op_load_accumulator = 3'b101,
        op_store_accumulator = 3'b110,
        op_fetch_register = 3'b111
    } dsa_op_t;

    // ============================================================
    // Instruction word as issued by the decoder
    typedef struct packed {
        logic valid;
        dsa_op_t op;
        logic [`DSA_ADDR_W-1:0] addr;
        logic [`DSA_DATA_W-1:0] imm;
    } dsa_instr_t;

    // ============================================================
    // Status flags touched by these instructions
    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
        logic overflow_flag;
    } dsa_flags_t;

    // ============================================================
    // Register file write request
    typedef struct packed {
        logic we;
        logic [`DSA_ADDR_W-1:0] addr;
        logic [`DSA_DATA_W-1:0] data;
    } dsa_wr_t;

endpackage

// >>> verilog/dsa_regfile.sv
// Data register file with registered read data
`include "dsa_regs.svh"

module dsa_regfile (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire dsa_pkg::dsa_wr_t i_wr,
    input wire logic [`DSA_ADDR_W-1:0] i_raddr,
    output logic [`DSA_DATA_W-1:0] o_rdata
);
    import dsa_pkg::*;

    // ============================================================
    // State
    typedef struct packed {
        logic [`DSA_DEPTH-1:0][`DSA_DATA_W-1:0] mem;
        logic [`DSA_DATA_W-1:0] rdata;
    } dsa_rf_state_t;

    dsa_rf_state_t s_reg;
    dsa_rf_state_t s_next;

    // Read old contents, then apply write
    always_comb begin
        s_next = s_reg;
        s_next.rdata = s_reg.mem[i_raddr];
        if (i_wr.we) begin
            s_next.mem[i_wr.addr] = i_wr.data;
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_rdata = s_reg.rdata;
endmodule // dsa_regfile

// >>> verilog/dsa_alu.sv
// Decrement and subtract execution datapath
// Notes for the next engineer
// One stage: an instruction taken on one edge retires on the next.
// Register file reads are issued with the instruction, so the operand
// arrives in the same cycle as the pending instruction word.
// A write retiring on the edge of that read is not yet in the file,
// hence the one-entry forward path below.
// Accumulator and carry live here, so back-to-back dependencies are
// exact without a stall; o_ready is therefore tied high.
// Carry and digit carry hold a borrow: set means a borrow occurred.
// Decrement touches the zero flag only, the other three hold.
// Load, store and fetch exist only to seed and observe registers,
// and leave every flag as it was.
// A nop or an instruction without valid retires nothing.
`include "dsa_regs.svh"

module dsa_alu (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire dsa_pkg::dsa_instr_t i_instr,
    output logic o_ready,
    output logic o_done,
    output logic [`DSA_DATA_W-1:0] o_result,
    output logic [`DSA_DATA_W-1:0] o_accumulator,
    output dsa_pkg::dsa_flags_t o_flags
);
    import dsa_pkg::*;

    // ============================================================
    // Subtract result bundle
    typedef struct packed {
        logic [`DSA_DATA_W-1:0] diff;
        dsa_flags_t flags;
    } dsa_sub_t;

    // ============================================================
    // State
    typedef struct packed {
        dsa_instr_t pend;
        logic [`DSA_DATA_W-1:0] accumulator;
        dsa_flags_t flags;
        logic fwd_valid;
        logic [`DSA_ADDR_W-1:0] fwd_addr;
        logic [`DSA_DATA_W-1:0] fwd_data;
        logic done;
        logic [`DSA_DATA_W-1:0] result;
    } dsa_state_t;

    dsa_state_t s_reg;
    dsa_state_t s_next;
    dsa_wr_t wr;
    logic [`DSA_DATA_W-1:0] rf_rdata;
    logic [`DSA_DATA_W-1:0] operand;
    dsa_sub_t sub_res;

    // ============================================================
    // Zero test shared by every flag update
    function automatic logic is_zero(input logic [`DSA_DATA_W-1:0] v);
        return (v == `DSA_ZERO_BYTE);
    endfunction

    // ============================================================
    // Register decrement, wraps from zero to all ones
    function automatic logic [`DSA_DATA_W-1:0] dec_byte(
        input logic [`DSA_DATA_W-1:0] v
    );
        return v - `DSA_ONE;
    endfunction

    // ============================================================
    // Ops whose result goes back into the register file
    function automatic logic writes_reg(input dsa_op_t op);
        logic w;
        w = 1'b0;
        case (op)
            op_decrement_to_register,
            op_subtract_to_register,
            op_store_accumulator: begin
                w = 1'b1;
            end
            default: begin
                w = 1'b0;
            end
        endcase
        return w;
    endfunction

    // ============================================================
    // Subtract a minus b minus borrow-in with all four flags
    function automatic dsa_sub_t sub_flags(
        input logic [`DSA_DATA_W-1:0] a,
        input logic [`DSA_DATA_W-1:0] b,
        input logic bin
    );
        logic [`DSA_DATA_W:0] full;
        logic [`DSA_DC_BIT:0] low;
        dsa_sub_t r;
        full = {1'b0, a} - {1'b0, b} - {{`DSA_DATA_W{1'b0}}, bin};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
        r.diff = full[`DSA_DATA_W-1:0];
        r.flags.carry = full[`DSA_C_BIT]; // Borrow out of bit 7
        r.flags.digit_carry_flag = low[`DSA_DC_BIT]; // Bit 3 borrow
        r.flags.zero = is_zero(r.diff);
        // Signed overflow: operands differ in sign, result sign flips
        r.flags.overflow_flag = (a[7] ^ b[7]) & (a[7] ^ r.diff[7]);
        return r;
    endfunction

    // ============================================================
    // Register file, read issued with the instruction
    dsa_regfile u_regfile (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_wr(wr),
        .i_raddr(i_instr.addr),
        .o_rdata(rf_rdata)
    );

    // ============================================================
    // Operand selection
    // Forward last write, the file returns pre-write data
    always_comb begin
        operand = rf_rdata;
        if (s_reg.fwd_valid && (s_reg.fwd_addr == s_reg.pend.addr)) begin
            operand = s_reg.fwd_data;
        end
    end

    // ============================================================
    // Subtractor input
    // Borrow-in only for the with-carry variant
    always_comb begin
        if (s_reg.pend.op == op_subtract_borrow_to_accumulator) begin
            sub_res = sub_flags(s_reg.accumulator, operand,
                                s_reg.flags.carry);
        end else begin
            sub_res = sub_flags(s_reg.accumulator, operand, 1'b0);
        end
    end

    // ============================================================
    // Execute stage: one instruction retires per clock
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.fwd_valid = 1'b0;
        s_next.pend = i_instr;
        s_next.pend.valid = i_instr.valid && (i_instr.op != op_nop);
        // Write port defaults; enable decoded from the pending op
        wr.we = s_reg.pend.valid && writes_reg(s_reg.pend.op);
        wr.addr = s_reg.pend.addr;
        wr.data = `DSA_ZERO_BYTE;
        if (s_reg.pend.valid) begin
            s_next.done = 1'b1;
            case (s_reg.pend.op)
                op_decrement_to_register: begin
                    wr.data = dec_byte(operand);
                    s_next.flags.zero = is_zero(wr.data);
                end
                op_subtract_to_accumulator,
                op_subtract_borrow_to_accumulator: begin
                    s_next.accumulator = sub_res.diff;
                    s_next.flags = sub_res.flags;
                end
                op_subtract_to_register: begin
                    wr.data = sub_res.diff;
                    s_next.flags = sub_res.flags;
                end
                op_load_accumulator: begin
                    s_next.accumulator = s_reg.pend.imm;
                end
                op_store_accumulator: begin
                    wr.data = s_reg.accumulator;
                end
                op_fetch_register: begin
                    s_next.accumulator = operand;
                end
                default: begin
                    s_next.done = 1'b0;
                end
            endcase
            if (wr.we) begin
                s_next.fwd_valid = 1'b1;
                s_next.fwd_addr = wr.addr;
                s_next.fwd_data = wr.data;
                s_next.result = wr.data;
            end else begin
                s_next.result = s_next.accumulator;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_reg <= '0;
            s_reg.accumulator <= `DSA_ACC_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ============================================================
    // Outputs, all from the state register except ready
    assign o_ready = 1'b1; // No stall condition exists
    assign o_done = s_reg.done;
    assign o_result = s_reg.result;
    assign o_accumulator = s_reg.accumulator;
    assign o_flags = s_reg.flags;
endmodule // dsa_alu

// >>> bench/dsa_alu_props.sv
// Assertion checker for the decrement and subtract datapath
`include "dsa_regs.svh"

module dsa_alu_props
    import dsa_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire dsa_pkg::dsa_instr_t i_instr,
    input wire logic o_ready,
    input wire logic o_done,
    input wire logic [`DSA_DATA_W-1:0] o_result,
    input wire logic [`DSA_DATA_W-1:0] o_accumulator,
    input wire dsa_pkg::dsa_flags_t o_flags
);
    // ============================================================
    // Properties
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Instruction taken this edge
    wire take_w = i_instr.valid && i_instr.op != op_nop;
    wire [2:0] op_w = i_instr.op;

    dec_zero_only_a: assert property (take_w && op_w == 3'h1 |-> ##2
        o_done && o_flags.zero == (o_result == 8'h00) &&
        o_flags[3:2] == $past(o_flags[3:2]) && o_flags[0] == $past(o_flags[0]))
        else $error("decrement retire wrong");
    sub_acc_a: assert property (take_w && op_w == 3'h2 |-> ##2
        o_done && o_accumulator == o_result) else $error("sub to acc wrong");
    sub_reg_a: assert property (take_w && op_w == 3'h3 |-> ##2
        o_done && $stable(o_accumulator)) else $error("sub to reg wrong");
    borrow_acc_a: assert property (take_w && op_w == 3'h4 |-> ##2
        o_done && o_accumulator == o_result) else $error("sub borrow wrong");
    zero_flag_a: assert property (take_w && op_w inside {[1:4]}
        |-> ##2 o_flags.zero == (o_result == 8'h00))
        else $error("zero flag wrong");
    done_cause_a: assert property (o_done |-> $past(take_w, 2))
        else $error("done without instruction");

    // Main scenarios reached
    cover property (take_w && op_w == 3'h4 && o_flags.carry);
    cover property (take_w && op_w == 3'h1 ##2 o_flags.zero);
    cover property (o_done && o_flags.overflow_flag);
endmodule // dsa_alu_props

bind dsa_alu dsa_alu_props dsa_alu_props_i (.i_clk, .i_reset, .i_instr,
    .o_ready, .o_done, .o_result, .o_accumulator, .o_flags);

// >>> bench/tb_decrement_subtract_alu_ops.sv
// Testbench for the decrement and subtract datapath
module tb_decrement_subtract_alu_ops;
    import dsa_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ============================================================
    // Stimulus, model and checks
    logic i_clk = 0;
    logic i_reset = 1;
    dsa_instr_t i_instr = '0;
    logic o_ready, o_done;
    logic [7:0] o_result, o_accumulator, m_acc, m_res;
    logic [7:0] m_reg [16];
    logic [19:0] exp_q [$];
    logic [19:0] exp_v;
    dsa_flags_t o_flags, m_f;
    int n_mismatch = 0, tests_run = 0, cyc = 0;

    dsa_alu dsa_alu_i (.i_clk(i_clk), .i_reset(i_reset), .i_instr(i_instr),
        .o_ready(o_ready), .o_done(o_done), .o_result(o_result),
        .o_accumulator(o_accumulator), .o_flags(o_flags));
    wire [20:0] seen_w = {o_ready, o_result, o_accumulator, o_flags};

    // Clock and hang guard
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask

    // Model one instruction, queue its retire, drive it next edge
    task automatic issue(input logic v, input dsa_op_t op,
                         input logic [3:0] a, input logic [7:0] d);
        logic [8:0] w;
        logic [4:0] h;
        logic [7:0] b;
        logic c;
        b = m_reg[a];
        c = (op == op_subtract_borrow_to_accumulator) & m_f.carry;
        w = {1'b0, m_acc} - {1'b0, b} - {8'h00, c};
        h = {1'b0, m_acc[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
        if (v) begin
            case (op)
                op_decrement_to_register: begin
                    m_res = b - 8'h01;
                    m_reg[a] = m_res;
                    m_f.zero = (m_res == 8'h00);
                end
                op_subtract_to_accumulator, op_subtract_to_register,
                op_subtract_borrow_to_accumulator: begin
                    m_res = w[7:0];
                    m_f = {w[8], h[4], m_res == 8'h00,
                           m_acc[7] != b[7] && m_res[7] != m_acc[7]};
                    if (op == op_subtract_to_register) begin
                        m_reg[a] = m_res;
                    end else begin
                        m_acc = m_res;
                    end
                end
                op_load_accumulator: begin
                    m_res = d;
                    m_acc = d;
                end
                op_store_accumulator: begin
                    m_res = m_acc;
                    m_reg[a] = m_acc;
                end
                op_fetch_register: begin
                    m_res = b;
                    m_acc = b;
                end
                default: begin
                end
            endcase
            if (op != op_nop) begin
                exp_q.push_back({m_res, m_acc, m_f});
            end
        end
        @(posedge i_clk);
        i_instr <= {v, op, a, d};
    endtask

    // Idle the instruction port for a few cycles
    task automatic gap(input int n);
        @(posedge i_clk);
        i_instr <= '0;
        repeat (n) @(posedge i_clk);
    endtask

    // Compare every retire against the model, mid-cycle
    always @(negedge i_clk) begin
        if (!i_reset && o_done) begin
            if (exp_q.size() > 0) begin
                exp_v = exp_q.pop_front();
                check(seen_w, {1'b1, exp_v});
                check(21'(o_flags), 21'(exp_v[3:0]));
            end else begin
                check(21'(o_done), 21'h00_0000);
            end
        end
    end

    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Directed borrow cases, then random instruction mix
    initial begin
        void'($urandom(85908));
        m_acc = 8'h00;
        m_f = '0;
        foreach (m_reg[k]) m_reg[k] = 8'h00;
        repeat (20) @(posedge i_clk);
        i_reset <= 1'b0;
        issue(1'b1, op_load_accumulator, 4'h0, 8'h77);
        issue(1'b1, op_store_accumulator, 4'h1, 8'h00);
        issue(1'b1, op_load_accumulator, 4'h0, 8'h80);
        issue(1'b1, op_subtract_borrow_to_accumulator, 4'h1, 8'h00);
        gap(2);
        issue(1'b1, op_load_accumulator, 4'h0, 8'h00);
        issue(1'b1, op_subtract_to_accumulator, 4'h1, 8'h00);
        issue(1'b1, op_load_accumulator, 4'h0, 8'h80);
        issue(1'b1, op_subtract_borrow_to_accumulator, 4'h1, 8'h00);
        issue(1'b1, op_subtract_to_register, 4'h1, 8'h00);
        issue(1'b1, op_decrement_to_register, 4'h2, 8'h00);
        issue(1'b1, op_decrement_to_register, 4'h2, 8'h00);
        gap(2);
        repeat (300) begin
            issue($urandom_range(7) != 0, dsa_op_t'($urandom_range(7)),
                  4'($urandom_range(3)), 8'($urandom));
            if ($urandom_range(3) == 0) begin
                gap(1);
            end
        end
        gap(4);
        @(negedge i_clk);
        check(21'(exp_q.size()), 21'h00_0000);
        close_out();
    end
endmodule // tb_decrement_subtract_alu_ops
